// *** hdl/bpsv_pkg.sv ***
// Constants, register map and state types of the buck sequencing and protection block
//--------------------------------------------------------------------------------
//--------------------------------------------------------------------------------
package bpsv_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_VCODE  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RETRY  = 8'h0C;

  // Field positions, reset values and response codes
  localparam int   CTRL_EN_BIT  = 0;
  localparam logic CTRL_EN_RST  = 1'b1;
  localparam int   ST_OVL_BIT   = 4;
  localparam int   ST_OC_BIT    = 5;
  localparam int   ST_UV_BIT    = 6;
  localparam int   ST_PG_BIT    = 7;
  localparam int   VC_TGT_LSB   = 8;
  localparam int   VC_REF_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Voltage code decode, millivolt units
  localparam logic [4:0]  CODE_OFF     = 5'h1F;
  localparam logic [10:0] CODE_TOP_MV  = 11'h73A;
  localparam logic [10:0] CODE_STEP_MV = 11'h019;
  localparam logic [10:0] SS_RAMP_MV   = 11'h001;

  // Soft-start and hiccup timing in phase cycles, duty ceiling and retry limit
  localparam logic [10:0] SS_HIZ_LAST   = 11'h01F;
  localparam logic [10:0] SS_CLAMP_LAST = 11'h0B5;
  localparam logic [10:0] SS_LAST       = 11'h7FF;
  localparam logic [10:0] OC_WAIT_LAST  = 11'h7FF;
  localparam logic [7:0]  DUTY_MAX      = 8'hFF;
  localparam logic [15:0] RETRY_MAX     = 16'hFFFF;

  // Synchronised flag positions
  localparam int FLG_OC   = 0;
  localparam int FLG_OV   = 1;
  localparam int FLG_LVL  = 2;
  localparam int FLG_UV   = 3;
  localparam int FLG_EN   = 4;
  localparam int FLG_POR  = 5;
  localparam int FLG_TERM = 6;
  localparam int FLG_W    = 7;

  typedef enum logic [2:0] {
    ST_OFF, ST_SS_HIZ, ST_SS_CLAMP, ST_SS_RAMP, ST_RUN, ST_OC_WAIT, ST_OV
  } bpsv_state_t;

  // Whole state of the block
  typedef struct packed {
    bpsv_state_t       st;
    logic [10:0]       cnt;
    logic [10:0]       ref_mv;
    logic [4:0]        cur_code;
    logic [4:0]        tgt_code;
    logic [4:0]        samp_code;
    logic              stable;
    logic              step_ph;
    logic              ov_drive;
    logic              ov_latch;
    logic [7:0]        duty;
    logic [4:0]        code_m;
    logic [4:0]        code_s;
    logic [FLG_W-1:0]  flg_m;
    logic [FLG_W-1:0]  flg_s;
    logic [2:0]        pwm_m;
    logic [2:0]        pwm_s;
    logic              term_d;
    logic              sw_en;
    logic [15:0]       retries;
    logic [2:0]        pwm_o;
    logic [2:0]        pwm_oe_n;
    logic              pwr_good;
    logic              ref_inh;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } bpsv_regs_t;

endpackage

// *** hdl/bpsv_top.sv ***
// Sequencing, protection and reference stepping core with AXI4-Lite registers
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
module bpsv_top (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address and data
  input  wire logic [bpsv_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [bpsv_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [bpsv_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [bpsv_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Asynchronous pins and comparator results
  input  wire logic [4:0]                    voltage_code,
  input  wire logic                          supply_por_ok_in,
  input  wire logic                          enable_in,
  input  wire logic                          oc_cmp_in,
  input  wire logic                          ov_cmp_in,
  input  wire logic                          at_level_cmp_in,
  input  wire logic                          uv_cmp_in,
  input  wire logic                          phase1_term_in,
  input  wire logic [2:0]                    pwm_req_in,
  // Driver side and analog controls
  output logic [2:0]                         pwm_out,
  output logic [2:0]                         pwm_oe_n,
  output logic                               power_good_out,
  output logic [10:0]                        reference_level,
  output logic                               reference_inhibit,
  output logic [7:0]                         duty_limit
);
  import bpsv_pkg::*;

  bpsv_regs_t s_r;
  bpsv_regs_t s_nxt;

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------

  // Reference in millivolts for a code
  // The shutdown code is never a live target, so its value is never used
  function automatic logic [10:0] code_mv(input logic [4:0] code);
    logic [15:0] prod;
    prod = 16'(CODE_STEP_MV) * 16'(code);
    return CODE_TOP_MV - prod[10:0];
  endfunction

  // True for a mapped, word-aligned register offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_VCODE) || (a == REG_RETRY);
  endfunction

  //----------------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------------

  // All state is computed here and registered once below
  always_comb begin
    logic tick;
    logic run_ok;
    logic oc_ev;
    logic retry_clr;
    logic [10:0] ss_top;
    tick      = 1'b0;
    run_ok    = 1'b0;
    oc_ev     = 1'b0;
    retry_clr = 1'b0;
    ss_top    = '0;
    s_nxt     = s_r;

    // Two-stage synchronisers; only the second stage feeds logic
    s_nxt.code_m = voltage_code;
    s_nxt.code_s = s_r.code_m;
    s_nxt.flg_m  = {phase1_term_in, supply_por_ok_in, enable_in, uv_cmp_in,
                    at_level_cmp_in, ov_cmp_in, oc_cmp_in};
    s_nxt.flg_s  = s_r.flg_m;
    // The modulator request is a pin as well; it lags three clocks
    s_nxt.pwm_m  = pwm_req_in;
    s_nxt.pwm_s  = s_r.pwm_m;
    s_nxt.term_d = s_r.flg_s[FLG_TERM];

    // One switching cycle per rising termination edge of phase one
    tick   = s_r.flg_s[FLG_TERM] & ~s_r.term_d;
    run_ok = s_r.flg_s[FLG_POR] & s_r.flg_s[FLG_EN] & s_r.sw_en &
             (s_r.code_s != CODE_OFF);

    // Code changes are confirmed only on cycle boundaries; a change must hold one cycle
    if (tick) begin
      if (s_r.code_s != s_r.samp_code) begin
        s_nxt.samp_code = s_r.code_s;
        s_nxt.stable    = 1'b0;
      end else if (!s_r.stable) begin
        s_nxt.stable = 1'b1;
        if (s_r.samp_code != CODE_OFF) begin
          s_nxt.tgt_code = s_r.samp_code;
        end
      end
    end

    // Sequencer; supply loss outranks overvoltage, which outranks the rest
    if (!s_r.flg_s[FLG_POR]) begin
      s_nxt.st       = ST_OFF;
      s_nxt.ov_latch = 1'b0;
      s_nxt.ov_drive = 1'b0;
    end else if (s_r.flg_s[FLG_OV]) begin
      s_nxt.st       = ST_OV;
      s_nxt.ov_latch = 1'b1;
      s_nxt.ov_drive = 1'b1;
    end else begin
      unique case (s_r.st)
        ST_OFF: begin
          if (run_ok) begin
            s_nxt.st        = ST_SS_HIZ;
            // Present code becomes the target the ramp aims at
            s_nxt.cnt       = '0;
            s_nxt.samp_code = s_r.code_s;
            s_nxt.tgt_code  = s_r.code_s;
            s_nxt.stable    = 1'b1;
          end
        end

        // One count runs through all three soft-start phases
        ST_SS_HIZ, ST_SS_CLAMP, ST_SS_RAMP: begin
          if (!run_ok) begin
            s_nxt.st = ST_OFF;
          end else if (s_r.flg_s[FLG_OC]) begin
            s_nxt.st  = ST_OC_WAIT;
            s_nxt.cnt = '0;
            oc_ev     = 1'b1;
          end else if (tick) begin
            s_nxt.cnt = s_r.cnt + 11'h001;
            if (s_r.st == ST_SS_HIZ && s_r.cnt == SS_HIZ_LAST) begin
              s_nxt.st = ST_SS_CLAMP;
            end else if (s_r.st == ST_SS_CLAMP && s_r.cnt == SS_CLAMP_LAST) begin
              s_nxt.st = ST_SS_RAMP;
            end else if (s_r.st == ST_SS_RAMP && s_r.cnt == SS_LAST) begin
              s_nxt.st       = ST_RUN;
              s_nxt.cur_code = s_r.tgt_code;
              s_nxt.step_ph  = 1'b0;
            end
          end
        end

        // Regulation; a confirmed code is walked one step at a time
        ST_RUN: begin
          if (!run_ok) begin
            s_nxt.st = ST_OFF;
          end else if (s_r.flg_s[FLG_OC]) begin
            s_nxt.st  = ST_OC_WAIT;
            s_nxt.cnt = '0;
            oc_ev     = 1'b1;
          end else if (tick) begin
            // Step one code every second cycle toward the target
            if (s_r.cur_code == s_r.tgt_code) begin
              s_nxt.step_ph = 1'b0;
            end else begin
              s_nxt.step_ph = ~s_r.step_ph;
              if (s_r.step_ph) begin
                if (s_r.cur_code < s_r.tgt_code) begin
                  s_nxt.cur_code = s_r.cur_code + 5'h01;
                end else begin
                  s_nxt.cur_code = s_r.cur_code - 5'h01;
                end
              end
            end
          end
        end

        ST_OC_WAIT: begin
          // Hiccup retries keep going while enabled
          if (!run_ok) begin
            s_nxt.st = ST_OFF;
          end else if (tick) begin
            s_nxt.cnt = s_r.cnt + 11'h001;
            if (s_r.cnt == OC_WAIT_LAST) begin
              s_nxt.st  = ST_SS_HIZ;
              s_nxt.cnt = '0;
            end
          end
        end

        ST_OV: begin
          // Latched: only a supply power cycle leaves this state
          if (s_r.flg_s[FLG_LVL]) begin
            s_nxt.ov_drive = 1'b0;
          end
          s_nxt.st = ST_OV;
        end

        // The eighth state code is unused; an upset there falls back to off
        default: begin
          s_nxt.st = ST_OFF;
        end
      endcase
    end

    // Reference and duty limit follow the state just chosen
    // The ramp moves only on ticks inside the ramp, never on entry
    ss_top = code_mv(s_nxt.tgt_code);
    unique case (s_nxt.st)
      ST_SS_RAMP: begin
        if (tick && s_r.st == ST_SS_RAMP) begin
          if (s_r.ref_mv + SS_RAMP_MV >= ss_top) begin
            s_nxt.ref_mv = ss_top;
          end else begin
            s_nxt.ref_mv = s_r.ref_mv + SS_RAMP_MV;
          end
          if (s_r.duty != DUTY_MAX) begin
            s_nxt.duty = s_r.duty + 8'h01;
          end
        end
      end
      ST_RUN: begin
        s_nxt.ref_mv = code_mv(s_nxt.cur_code);
        s_nxt.duty   = DUTY_MAX;
      end
      default: begin
        s_nxt.ref_mv = '0;
        s_nxt.duty   = '0;
      end
    endcase
    s_nxt.ref_inh = !(s_nxt.st == ST_SS_RAMP || s_nxt.st == ST_RUN);

    // Pin drive from the next state, so protection acts on the next edge
    // Costs logic depth but saves a clock of reaction time
    unique case (s_nxt.st)
      ST_OV: begin
        s_nxt.pwm_o    = '0;
        s_nxt.pwm_oe_n = {3{~s_nxt.ov_drive}};
      end
      ST_SS_CLAMP: begin
        s_nxt.pwm_o    = '0;
        s_nxt.pwm_oe_n = '0;
      end
      ST_SS_RAMP, ST_RUN: begin
        s_nxt.pwm_o    = s_r.pwm_s;
        s_nxt.pwm_oe_n = '0;
      end
      default: begin
        s_nxt.pwm_o    = '0;
        s_nxt.pwm_oe_n = '1;
      end
    endcase

    // Undervoltage only masks power-good and is never remembered
    // Run begins only at the last soft-start tick, so no early good
    s_nxt.pwr_good = (s_nxt.st == ST_RUN) && !s_r.flg_s[FLG_UV];

    // Shutdown counter saturates
    // so a long hiccup run never wraps back to a small count
    if (oc_ev && s_r.retries != RETRY_MAX) begin
      s_nxt.retries = s_r.retries + 16'h0001;
    end

    // AXI write: address and data accepted independently
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_full = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = addr_hit(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      // Only lane zero carries a field; other lanes are ignored
      if (s_r.aw_addr == REG_CTRL && s_r.wstrb[0]) begin
        s_nxt.sw_en = s_r.wdata[CTRL_EN_BIT];
      end
      if (s_r.aw_addr == REG_RETRY) begin
        retry_clr = 1'b1;
      end
    end

    // A shutdown in the clearing cycle still counts
    if (retry_clr) begin
      s_nxt.retries = {15'h0000, oc_ev};
    end
    // A channel closes once its item is held, reopens after the response
    s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;

    // AXI read: one outstanding, data registered with the response
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      // Unmapped offsets read as zero with an error response
      s_nxt.rdata  = '0;
      unique case (s_axi_araddr)
        REG_CTRL: s_nxt.rdata[CTRL_EN_BIT] = s_r.sw_en;
        REG_STATUS: begin
          s_nxt.rdata[2:0]        = s_r.st;
          s_nxt.rdata[ST_OVL_BIT] = s_r.ov_latch;
          s_nxt.rdata[ST_OC_BIT]  = s_r.flg_s[FLG_OC];
          s_nxt.rdata[ST_UV_BIT]  = s_r.flg_s[FLG_UV];
          s_nxt.rdata[ST_PG_BIT]  = s_r.pwr_good;
        end
        REG_VCODE: begin
          s_nxt.rdata[4:0]                       = s_r.cur_code;
          s_nxt.rdata[VC_TGT_LSB +: 5]           = s_r.tgt_code;
          s_nxt.rdata[VC_REF_LSB +: 11]          = s_r.ref_mv;
        end
        REG_RETRY: s_nxt.rdata[15:0] = s_r.retries;
        default:   s_nxt.rdata = '0;
      endcase
    end
    // Address refused while a response waits: one read at a time
    s_nxt.arready = !s_nxt.rvalid;
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------

  // Synchronous reset; outputs float and the bus is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r           <= '0;
      s_r.sw_en     <= CTRL_EN_RST;
      s_r.pwm_oe_n  <= '1;
      s_r.ref_inh   <= 1'b1;
      // Codes start at shutdown so nothing steps before a start
      s_r.samp_code <= CODE_OFF;
      s_r.tgt_code  <= CODE_OFF;
      s_r.cur_code  <= CODE_OFF;
      s_r.st        <= ST_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs, straight from the state register
  //----------------------------------------------------------------------------
  assign s_axi_awready     = s_r.awready;
  assign s_axi_wready      = s_r.wready;
  assign s_axi_bvalid      = s_r.bvalid;
  assign s_axi_bresp       = s_r.bresp;
  assign s_axi_arready     = s_r.arready;
  assign s_axi_rvalid      = s_r.rvalid;
  assign s_axi_rdata       = s_r.rdata;
  assign s_axi_rresp       = s_r.rresp;
  assign pwm_out           = s_r.pwm_o;
  assign pwm_oe_n          = s_r.pwm_oe_n;
  assign power_good_out    = s_r.pwr_good;
  assign reference_level   = s_r.ref_mv;
  assign reference_inhibit = s_r.ref_inh;
  assign duty_limit        = s_r.duty;

endmodule // bpsv_top

// *** verif/bpsv_assertions.sv ***
// Concurrent checks on the protection and sequencing pins of the core
`timescale 1ns/1ns
module bpsv_assertions
  import bpsv_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Comparator inputs
  input wire logic        supply_por_ok_in,
  input wire logic        oc_cmp_in,
  input wire logic        ov_cmp_in,
  input wire logic        at_level_cmp_in,
  input wire logic        uv_cmp_in,
  // Driver and analog outputs
  input wire logic [2:0]  pwm_out,
  input wire logic [2:0]  pwm_oe_n,
  input wire logic        power_good_out,
  input wire logic [10:0] reference_level,
  input wire logic        reference_inhibit,
  input wire logic [7:0]  duty_limit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //--------------------------------------------------------------
  // Held comparator conditions
  //--------------------------------------------------------------
  // Five samples cover the two-stage synchroniser plus the state update
  sequence s_por_lost; !supply_por_ok_in [*5]; endsequence
  sequence s_ov_high; (ov_cmp_in && !at_level_cmp_in && supply_por_ok_in) [*5]; endsequence
  sequence s_oc_high; (oc_cmp_in && !ov_cmp_in) [*5]; endsequence
  sequence s_uv_high; uv_cmp_in [*5]; endsequence
  //--------------------------------------------------------------
  // Properties
  //--------------------------------------------------------------
  property p_por_hiz; s_por_lost |-> pwm_oe_n == 3'b111 && !power_good_out; endproperty
  a_por_hiz: assert property (p_por_hiz) else $error("outputs driven without supply");
  property p_ov_low; s_ov_high |-> pwm_oe_n == 3'b000 && pwm_out == 3'b000; endproperty
  a_ov_low: assert property (p_ov_low) else $error("overvoltage not driving low");
  // Shutdown floats, unless a clamp or overvoltage drive already holds them low
  property p_oc_off;
    s_oc_high |-> !power_good_out && (pwm_oe_n == 3'b111 || pwm_out == 3'b000);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent left switching on");
  property p_uv_pg; s_uv_high |-> !power_good_out; endproperty
  a_uv_pg: assert property (p_uv_pg) else $error("power good high in undervoltage");
  property p_inh_ref; reference_inhibit |-> reference_level == 11'h000; endproperty
  a_inh_ref: assert property (p_inh_ref) else $error("reference live while inhibited");
  property p_pg_run;
    power_good_out |-> duty_limit == DUTY_MAX && !reference_inhibit && pwm_oe_n == 3'b000;
  endproperty
  a_pg_run: assert property (p_pg_run) else $error("power good before run");
  property p_duty;
    $changed(duty_limit) |-> duty_limit == $past(duty_limit) + 8'h01
      || duty_limit == DUTY_MAX || duty_limit == 8'h00;
  endproperty
  a_duty: assert property (p_duty) else $error("duty ceiling jumped");
  // Ramp moves one millivolt, code steps one code, inhibit drops to zero
  property p_ref_step;
    $changed(reference_level) |-> reference_level == $past(reference_level) + 11'h001
      || reference_level == $past(reference_level) + 11'h019
      || reference_level + 11'h019 == $past(reference_level) || reference_level == 11'h000;
  endproperty
  a_ref_step: assert property (p_ref_step) else $error("reference step size wrong");
endmodule // bpsv_assertions

bind bpsv_top bpsv_assertions u_bpsv_chk (
  .aclk(aclk), .aresetn(aresetn), .supply_por_ok_in(supply_por_ok_in),
  .oc_cmp_in(oc_cmp_in), .ov_cmp_in(ov_cmp_in), .at_level_cmp_in(at_level_cmp_in),
  .uv_cmp_in(uv_cmp_in), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
  .power_good_out(power_good_out), .reference_level(reference_level),
  .reference_inhibit(reference_inhibit), .duty_limit(duty_limit)
);

// *** verif/bpsv_gate_drv_model.sv ***
// Behavioural gate-driver pair for each phase of the converter
`timescale 1ns/1ns
module bpsv_gate_drv_model (
  // Modulation inputs from the controller
  input  wire logic [2:0] pwm_in,
  input  wire logic [2:0] pwm_oe_n_in,
  // Switch states of each phase
  output logic      [2:0] upper_on,
  output logic      [2:0] lower_on
);
  // A floating input turns both switches off; a driven low turns the lower one on
  always_comb begin
    upper_on = ~pwm_oe_n_in & pwm_in;
    lower_on = ~pwm_oe_n_in & ~pwm_in;
  end
endmodule // bpsv_gate_drv_model

// *** verif/buck_protect_softstart_vid_test.sv ***
// Self-checking bench of the sequencing, protection and reference core
`timescale 1ns/1ns
module buck_protect_softstart_vid_test;
  import bpsv_pkg::*;
  //--------------------------------------------------------------
  // Signals
  //--------------------------------------------------------------
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, rd;
  logic [3:0]        wstrb = '0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid, pg, inh;
  logic [1:0]        bresp, rresp, rs;
  logic [4:0]        code = 5'h00;
  logic              por = 1, en = 1, oc = 0, ov = 0, lvl = 0, uv = 0, term = 0;
  logic [2:0]        req = '0, pwm, oe_n, hi_on, lo_on;
  logic [10:0]       ref_mv;
  logic [7:0]        duty;
  int                err_count = 0, checked = 0, ticks = 0, cycles = 0;

  bpsv_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .voltage_code(code), .supply_por_ok_in(por),
    .enable_in(en), .oc_cmp_in(oc), .ov_cmp_in(ov), .at_level_cmp_in(lvl),
    .uv_cmp_in(uv), .phase1_term_in(term), .pwm_req_in(req), .pwm_out(pwm),
    .pwm_oe_n(oe_n), .power_good_out(pg), .reference_level(ref_mv),
    .reference_inhibit(inh), .duty_limit(duty));
  bpsv_gate_drv_model u_drv (.pwm_in(pwm), .pwm_oe_n_in(oe_n), .upper_on(hi_on),
    .lower_on(lo_on));

  //--------------------------------------------------------------
  // Clock, phase ticks and timeout
  //--------------------------------------------------------------
  always #2 aclk = ~aclk;
  // Six clocks per switching cycle keeps 2048-cycle waits short
  initial forever begin
    repeat (3) @(posedge aclk);
    term <= 1'b1;
    repeat (3) @(posedge aclk);
    term <= 1'b0;
    ticks <= ticks + 1;
  end
  // Longest path is about 8500 ticks of six clocks
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      err_count++;
      end_sim();
    end
  end

  //--------------------------------------------------------------
  // Shared tasks
  //--------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    int t0;
    t0 = ticks;
    while (ticks < t0 + n) @(posedge aclk);
  endtask
  // Pins need about three clocks through the synchronisers
  task automatic settle();
    repeat (6) @(posedge aclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata; rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic st_is(input logic [2:0] e);
    rdr(REG_STATUS);
    chk(rd[2:0], e);
  endtask

  //--------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------
  task automatic t_softstart();
    wt(20);
    chk({oe_n, inh, ref_mv, duty}, {3'b111, 1'b1, 11'h000, 8'h00});
    wt(80);
    chk({oe_n, pwm, lo_on}, {6'b000_000, 3'b111});
    wt(150);
    req <= 3'b101;
    settle();
    chk({oe_n, pwm}, {3'b000, 3'b101});
    wt(1750);
    chk(pg, 1'b0);
    wt(70);
    chk({pg, ref_mv, duty}, {1'b1, CODE_TOP_MV, DUTY_MAX});
    st_is(3'h4);
  endtask
  task automatic t_code_step();
    code <= 5'h02;
    wt(2);
    chk(ref_mv, 11'h73A);
    wt(6);
    rdr(REG_VCODE);
    chk({rd[26:16], rd[12:8]}, {11'h708, 5'h02});
    code <= 5'h1E;
    wt(70);
    chk(ref_mv, 11'h44C);
  endtask
  task automatic t_uv();
    uv <= 1'b1;
    settle();
    chk(pg, 1'b0);
    st_is(3'h4);
    chk({rd[ST_PG_BIT], rd[ST_UV_BIT]}, 2'b01);
    uv <= 1'b0;
    settle();
    chk(pg, 1'b1);
  endtask
  task automatic t_regs();
    rdr(8'h10);
    chk({rs, rd}, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h14, 32'h0000_0001, 4'hF);
    chk(rs, RESP_SLVERR);
    rdr(REG_CTRL);
    chk(rd[CTRL_EN_BIT], CTRL_EN_RST);
    wr(REG_RETRY, 32'h0000_0000, 4'hF);
    wr(REG_CTRL, 32'h0000_0000, 4'h2);
    st_is(3'h4);
    wr(REG_CTRL, 32'h0000_0000, 4'hF);
    settle();
    chk(oe_n, 3'b111);
    st_is(3'h0);
    wr(REG_CTRL, 32'h0000_0001, 4'hF);
    wt(3);
    st_is(3'h1);
  endtask
  task automatic t_oc();
    oc <= 1'b1;
    settle();
    chk({oe_n, hi_on, lo_on}, {3'b111, 6'b000_000});
    rdr(REG_RETRY);
    chk(rd[15:0], 16'h0001);
    wt(2040);
    st_is(3'h5);
    wt(20);
    rdr(REG_RETRY);
    chk(rd[15:0], 16'h0002);
    oc <= 1'b0;
    wt(4110);
    st_is(3'h4);
  endtask
  task automatic t_off_ov();
    code <= CODE_OFF;
    wt(2);
    chk(oe_n, 3'b111);
    st_is(3'h0);
    code <= 5'h00;
    wt(2);
    st_is(3'h1);
    ov <= 1'b1;
    settle();
    chk({oe_n, pwm, lo_on}, {6'b000_000, 3'b111});
    ov <= 1'b0; lvl <= 1'b1;
    settle();
    chk(oe_n, 3'b111);
    lvl <= 1'b0; ov <= 1'b1;
    settle();
    chk(oe_n, 3'b000);
    ov <= 1'b0; lvl <= 1'b1;
    wt(40);
    st_is(3'h6);
    chk(rd[ST_OVL_BIT], 1'b1);
    lvl <= 1'b0; por <= 1'b0;
    settle();
    chk(oe_n, 3'b111);
    st_is(3'h0);
    chk(rd[ST_OVL_BIT], 1'b0);
    por <= 1'b1;
    wt(3);
    st_is(3'h1);
  endtask

  //--------------------------------------------------------------
  // Main sequence and verdict
  //--------------------------------------------------------------
  task automatic end_sim();
    $display("Errors %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_softstart();
    t_code_step();
    t_uv();
    t_regs();
    t_oc();
    t_off_ov();
    end_sim();
  end
endmodule // buck_protect_softstart_vid_test
